// ### smo_defs.vh
// constants for the sync monitor and output block
//
// How it works
// R01 - active video flag high only inside programmed start and end pixel positions
// R02 - writing 0x04 to the auto adjust register starts the automatic position search
// R03 - host refines the found start and end positions after the search finishes
// R04 - line sync edges within 100 ns of an accepted edge are ignored
// R05 - activity register reports all six sync inputs of both channels continuously
// R06 - selected channel register reports detail for the chosen channel only
// R07 - green sync activity needs 64 pulses with equal period and duty
// R08 - host gives line and frame sync activity top priority
// R09 - host trusts green sync activity only when line sync activity reads zero
// R10 - host keeps the green sync low pass filter bit set
// R11 - three level detection works on digitized green samples of the selected input
// R12 - host moves clamp start above 0x30 before checking three level sync
// R13 - line and frame repeats are plain buffered copies, never resynchronized
// R14 - line marker comes from pixel clock logic and marks each line start
// R15 - repeats and activity detection keep running during power down
// R16 - line repeat keeps period, polarity, width and format of its input
// R17 - with green sync selected the line repeat passes the whole embedded waveform
// R18 - line marker width in pixels and polarity programmable, trailing edge on pixel 0
// R19 - glitch filter is a hold-off counter loaded on each accepted edge
`ifndef SMO_DEFS_VH
`define SMO_DEFS_VH

// register indices, byte address is four times the index
`define SMO_IDX_SEL_INFO 8'h01
`define SMO_IDX_ACTIVITY 8'h02
`define SMO_IDX_MK_POL 8'h29
`define SMO_IDX_MK_WIDTH 8'h2a
`define SMO_IDX_SOG_CTL 8'h31
`define SMO_IDX_AUTO 8'h50
`define SMO_IDX_CTRL 8'h60
`define SMO_IDX_DE_START 8'h61
`define SMO_IDX_DE_END 8'h62
`define SMO_IDX_IRQ_STAT 8'h64
`define SMO_IDX_IRQ_EN 8'h65
`define SMO_IDX_IRQ_CLR 8'h66

// field positions
`define SMO_MK_POL_BIT 3
`define SMO_CTRL_CHAN_BIT 0
`define SMO_CTRL_SOG_BIT 1
`define SMO_CTRL_LPOL_BIT 2

// reset values and the auto adjust command
`define SMO_RST_SOG_CTL 8'h40
`define SMO_RST_MK_WIDTH 8'h20
`define SMO_RST_CTRL 8'h00
`define SMO_AUTO_DE_CMD 8'h04

// timing
`define SMO_CLK_NS 10
`define SMO_GLITCH_NS 100
`define SMO_GLITCH_CYC ((`SMO_GLITCH_NS + `SMO_CLK_NS - 1) / `SMO_CLK_NS)
`define SMO_ACT_TIMEOUT_CYC 1000000
`define SMO_SOG_PULSES 64

// three level sync and video thresholds on green samples
`define SMO_TRI_LOW 8'h10
`define SMO_TRI_HIGH 8'hc0
`define SMO_VIDEO_THR 8'h20

`endif

// ### smo_glitch.v
// hold-off glitch filter for a sliced line sync
`timescale 1ns/1ns
module smo_glitch (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire sig,
  output reg filt_ff
);
`include "smo_defs.vh"

  localparam integer HOLD = `SMO_GLITCH_CYC;
  reg [3:0] hold_ff;

  // accept an edge, then block further edges until the counter runs out
  always @(posedge clk) begin
    if (!nrst) begin
      filt_ff <= 1'b0;
      hold_ff <= 4'h0;
    end else if (ce) begin
      if (hold_ff != 4'h0) begin
        hold_ff <= hold_ff - 4'h1; // [R04]
      end else if (sig != filt_ff) begin
        filt_ff <= sig;
        hold_ff <= HOLD[3:0]; // [R19]
      end
    end
  end
endmodule // smo_glitch

// ### smo_activity.v
// activity and polarity detector for one sync input
`timescale 1ns/1ns
module smo_activity #(
  parameter NEED = 1,
  parameter TIMEOUT = 1000000
) (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire sig,
  output reg active_ff,
  output reg pol_ff
);

  reg prev_ff;
  reg [15:0] per_ff;
  reg [15:0] hi_ff;
  reg [15:0] last_per_ff;
  reg [15:0] last_hi_ff;
  reg [6:0] match_ff;
  reg [23:0] idle_ff;
  wire rise;
  wire same;

  assign rise = sig & ~prev_ff;
  assign same = (per_ff == last_per_ff) && (hi_ff == last_hi_ff);

  // measure period and high time, count matching pulses, time out when idle
  always @(posedge clk) begin
    if (!nrst) begin
      prev_ff <= 1'b0;
      per_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      last_per_ff <= 16'h0000;
      last_hi_ff <= 16'h0000;
      match_ff <= 7'h00;
      idle_ff <= 24'h000000;
      active_ff <= 1'b0;
      pol_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= sig;
      if (rise) begin
        per_ff <= 16'h0000;
        hi_ff <= 16'h0000;
        last_per_ff <= per_ff;
        last_hi_ff <= hi_ff;
        idle_ff <= 24'h000000;
        pol_ff <= (hi_ff > {1'b0, per_ff[15:1]}); // mostly high: active low pulses
        if (NEED == 1) begin
          active_ff <= 1'b1;
        end else if (same) begin
          if (match_ff == NEED[6:0] - 7'h1) begin
            active_ff <= 1'b1; // [R07]
          end else begin
            match_ff <= match_ff + 7'h1;
          end
        end else begin
          match_ff <= 7'h00;
        end
      end else begin
        if (per_ff != 16'hffff) per_ff <= per_ff + 16'h1;
        if (sig && hi_ff != 16'hffff) hi_ff <= hi_ff + 16'h1;
        if (idle_ff >= TIMEOUT[23:0]) begin
          active_ff <= 1'b0;
          match_ff <= 7'h00;
        end else begin
          idle_ff <= idle_ff + 24'h1;
        end
      end
    end
  end
endmodule // smo_activity

// ### smo_top.v
// sync monitor, repeats, line marker and active video flag with apb registers
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
// constants first, the timeout default below needs them
`include "smo_defs.vh"
module smo_top #(
  parameter ACT_TIMEOUT = `SMO_ACT_TIMEOUT_CYC
) (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire line_sync_input_a,
  input wire line_sync_input_b,
  input wire frame_sync_input_a,
  input wire frame_sync_input_b,
  input wire green_embedded_sync_input_a,
  input wire green_embedded_sync_input_b,
  input wire green_frame_sync,
  input wire [7:0] green_sample,
  input wire power_down,
  output wire line_sync_repeat,
  output wire frame_sync_repeat,
  output reg pixel_aligned_line_marker,
  output reg active_video_flag,
  output reg irq
);

  // register file
  reg [7:0] sog_ctl_ff;
  reg [7:0] auto_ff;
  reg [7:0] mk_pol_ff;
  reg [7:0] mk_width_ff;
  reg [7:0] ctrl_ff;
  reg [11:0] de_start_ff;
  reg [11:0] de_end_ff;
  reg [7:0] irq_stat_ff;
  reg [7:0] irq_en_ff;

  // raw inputs: [0] line a [1] frame a [2] green a [3] line b [4] frame b [5] green b
  wire [5:0] raw;
  wire [5:0] clean;
  wire [5:0] act;
  wire [5:0] pol;
  assign raw = {green_embedded_sync_input_b, frame_sync_input_b, line_sync_input_b,
                green_embedded_sync_input_a, frame_sync_input_a, line_sync_input_a};

  // glitch filter on line syncs, activity detector on all six inputs
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_in
      if (gi % 3 == 0) begin : g_line
        smo_glitch u_glitch (
          .clk(clk),
          .nrst(nrst),
          .ce(ce),
          .sig(raw[gi]),
          .filt_ff(clean[gi])
        );
      end else begin : g_pass
        assign clean[gi] = raw[gi];
      end
      smo_activity #(
        .NEED((gi % 3 == 2) ? `SMO_SOG_PULSES : 1),
        .TIMEOUT(ACT_TIMEOUT)
      ) u_act (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .sig(clean[gi]),
        .active_ff(act[gi]), // [R05] [R15]
        .pol_ff(pol[gi])
      );
    end
  endgenerate

  // channel and source selection
  wire chan_b;
  wire sog_sel;
  wire [2:0] sel_act;
  wire [2:0] sel_pol;
  assign chan_b = ctrl_ff[`SMO_CTRL_CHAN_BIT];
  assign sog_sel = ctrl_ff[`SMO_CTRL_SOG_BIT];
  assign sel_act = chan_b ? act[5:3] : act[2:0];
  assign sel_pol = chan_b ? pol[5:3] : pol[2:0];

  // plain buffered repeats, no flip-flop in the path
  wire line_raw_sel;
  wire frame_raw_sel;
  assign line_raw_sel = sog_sel ? (chan_b ? raw[5] : raw[2])
                                : (chan_b ? raw[3] : raw[0]); // [R16] [R17]
  assign frame_raw_sel = sog_sel ? green_frame_sync : (chan_b ? raw[4] : raw[1]);
  assign line_sync_repeat = line_raw_sel; // [R13] [R15]
  assign frame_sync_repeat = frame_raw_sel; // [R13] [R15]

  // filtered line sync, or unfiltered green sync when selected, drives the pixel timing
  wire line_clean_sel;
  wire line_active_lvl;
  reg line_prev_ff;
  wire line_start;
  assign line_clean_sel = sog_sel ? (chan_b ? clean[5] : clean[2])
                                  : (chan_b ? clean[3] : clean[0]);
  assign line_active_lvl = line_clean_sel ^ ctrl_ff[`SMO_CTRL_LPOL_BIT];
  assign line_start = line_active_lvl & ~line_prev_ff;

  // pixel counter and previous line length
  reg [11:0] pix_ff;
  reg [11:0] line_len_ff;
  wire run;
  assign run = ce & ~power_down;

  always @(posedge clk) begin
    if (!nrst) begin
      line_prev_ff <= 1'b0;
      pix_ff <= 12'h000;
      line_len_ff <= 12'hfff;
    end else if (run) begin
      line_prev_ff <= line_active_lvl;
      if (line_start) begin
        pix_ff <= 12'h000;
        line_len_ff <= pix_ff;
      end else if (pix_ff != 12'hfff) begin
        pix_ff <= pix_ff + 12'h1;
      end
    end
  end

  // marker: leading edge at line end minus width, trailing edge on pixel 0
  wire [11:0] mk_lead;
  wire mk_on;
  assign mk_lead = line_len_ff - {4'h0, mk_width_ff};
  assign mk_on = (mk_width_ff != 8'h00) && (pix_ff >= mk_lead) && !line_start; // [R18]

  always @(posedge clk) begin
    if (!nrst) begin
      pixel_aligned_line_marker <= 1'b0;
    end else if (run) begin
      pixel_aligned_line_marker <= mk_on ^ mk_pol_ff[`SMO_MK_POL_BIT]; // [R14] [R18]
    end
  end

  // active video flag from programmed window
  always @(posedge clk) begin
    if (!nrst) begin
      active_video_flag <= 1'b0;
    end else if (run) begin
      active_video_flag <= (de_end_ff > de_start_ff) && !line_start &&
                           (pix_ff >= de_start_ff) && (pix_ff < de_end_ff); // [R01]
    end
  end

  // automatic position search over one whole line
  localparam [2:0] AU_IDLE = 3'b001;
  localparam [2:0] AU_WAIT = 3'b010;
  localparam [2:0] AU_SCAN = 3'b100;
  reg [2:0] au_state_ff;
  reg [11:0] au_first_ff;
  reg [11:0] au_last_ff;
  reg au_seen_ff;
  reg au_done_ff;
  wire auto_cmd;
  wire bus_wr;
  wire [7:0] idx;
  assign idx = paddr[9:2];
  assign bus_wr = psel & penable & pready & pwrite & ~pslverr;
  assign auto_cmd = bus_wr && idx == `SMO_IDX_AUTO && pwdata[7:0] == `SMO_AUTO_DE_CMD;

  always @(posedge clk) begin
    if (!nrst) begin
      au_state_ff <= AU_IDLE;
      au_first_ff <= 12'h000;
      au_last_ff <= 12'h000;
      au_seen_ff <= 1'b0;
      au_done_ff <= 1'b0;
    end else if (run) begin
      au_done_ff <= 1'b0;
      case (au_state_ff)
        AU_IDLE: begin
          if (auto_cmd) au_state_ff <= AU_WAIT; // [R02]
        end
        AU_WAIT: begin
          au_seen_ff <= 1'b0;
          if (line_start) au_state_ff <= AU_SCAN;
        end
        AU_SCAN: begin
          if (line_start) begin
            au_state_ff <= AU_IDLE;
            au_done_ff <= au_seen_ff;
          end else if (green_sample > `SMO_VIDEO_THR) begin
            if (!au_seen_ff) au_first_ff <= pix_ff;
            au_last_ff <= pix_ff + 12'h1;
            au_seen_ff <= 1'b1;
          end
        end
        default: begin
          au_state_ff <= AU_IDLE;
        end
      endcase
    end
  end

  // three level detect: dip below low then rise above high within one line
  reg tri_low_ff;
  reg tri_line_ff;
  reg tri_ff;
  always @(posedge clk) begin
    if (!nrst) begin
      tri_low_ff <= 1'b0;
      tri_line_ff <= 1'b0;
      tri_ff <= 1'b0;
    end else if (run) begin
      if (line_start) begin
        tri_ff <= tri_line_ff;
        tri_line_ff <= 1'b0;
        tri_low_ff <= 1'b0;
      end else if (green_sample < `SMO_TRI_LOW) begin
        tri_low_ff <= 1'b1; // [R11]
      end else if (tri_low_ff && green_sample > `SMO_TRI_HIGH) begin
        tri_line_ff <= 1'b1; // [R11]
      end
    end
  end

  // selected channel detail and channel activity words
  wire [7:0] sel_info;
  wire [7:0] activity;
  assign sel_info = {1'b0, chan_b, tri_ff, sel_pol[1], sel_pol[0],
                     sel_act[2], sel_act[1], sel_act[0]}; // [R06]
  assign activity = {2'b00, act}; // [R05]

  // interrupt events: selected activity change, search done, three level change
  reg [2:0] sel_act_prev_ff;
  reg tri_prev_ff;
  wire [7:0] events;
  assign events = {5'h00, tri_ff != tri_prev_ff, au_done_ff, sel_act != sel_act_prev_ff};

  // apb decode of a mapped index
  function mapped;
    input [7:0] i;
    begin
      mapped = (i == `SMO_IDX_SEL_INFO) || (i == `SMO_IDX_ACTIVITY) ||
               (i == `SMO_IDX_MK_POL) || (i == `SMO_IDX_MK_WIDTH) ||
               (i == `SMO_IDX_SOG_CTL) || (i == `SMO_IDX_AUTO) ||
               (i == `SMO_IDX_CTRL) || (i == `SMO_IDX_DE_START) ||
               (i == `SMO_IDX_DE_END) || (i == `SMO_IDX_IRQ_STAT) ||
               (i == `SMO_IDX_IRQ_EN) || (i == `SMO_IDX_IRQ_CLR);
    end
  endfunction

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (idx)
      `SMO_IDX_SEL_INFO: rd_mux[7:0] = sel_info;
      `SMO_IDX_ACTIVITY: rd_mux[7:0] = activity;
      `SMO_IDX_MK_POL: rd_mux[7:0] = mk_pol_ff;
      `SMO_IDX_MK_WIDTH: rd_mux[7:0] = mk_width_ff;
      `SMO_IDX_SOG_CTL: rd_mux[7:0] = sog_ctl_ff;
      `SMO_IDX_AUTO: rd_mux[7:0] = auto_ff;
      `SMO_IDX_CTRL: rd_mux[7:0] = ctrl_ff;
      `SMO_IDX_DE_START: rd_mux[11:0] = de_start_ff;
      `SMO_IDX_DE_END: rd_mux[11:0] = de_end_ff;
      `SMO_IDX_IRQ_STAT: rd_mux[7:0] = irq_stat_ff;
      `SMO_IDX_IRQ_EN: rd_mux[7:0] = irq_en_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // apb slave: answer in the first access cycle
  always @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ((paddr[1:0] != 2'b00) | ~mapped(idx));
      // refused unaligned reads return zero, not the word behind the index
      if (psel && !penable && !pwrite) begin
        if (paddr[1:0] == 2'b00) begin
          prdata <= rd_mux;
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // register writes, search results and interrupt state
  always @(posedge clk) begin
    if (!nrst) begin
      sog_ctl_ff <= `SMO_RST_SOG_CTL;
      auto_ff <= 8'h00;
      mk_pol_ff <= 8'h00;
      mk_width_ff <= `SMO_RST_MK_WIDTH;
      ctrl_ff <= `SMO_RST_CTRL;
      de_start_ff <= 12'h000;
      de_end_ff <= 12'h000;
      irq_stat_ff <= 8'h00;
      irq_en_ff <= 8'h00;
      sel_act_prev_ff <= 3'b000;
      tri_prev_ff <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      sel_act_prev_ff <= sel_act;
      tri_prev_ff <= tri_ff;
      if (bus_wr) begin
        case (idx)
          `SMO_IDX_MK_POL: mk_pol_ff <= pwdata[7:0];
          `SMO_IDX_MK_WIDTH: mk_width_ff <= pwdata[7:0];
          `SMO_IDX_SOG_CTL: sog_ctl_ff <= pwdata[7:0];
          `SMO_IDX_AUTO: auto_ff <= pwdata[7:0];
          `SMO_IDX_CTRL: ctrl_ff <= pwdata[7:0];
          `SMO_IDX_DE_START: de_start_ff <= pwdata[11:0];
          `SMO_IDX_DE_END: de_end_ff <= pwdata[11:0];
          `SMO_IDX_IRQ_EN: irq_en_ff <= pwdata[7:0];
          default: ;
        endcase
      end
      // results land as a rough window for the host to refine
      if (au_done_ff && run) begin
        de_start_ff <= au_first_ff; // [R02] [R03]
        de_end_ff <= au_last_ff;
        auto_ff <= 8'h00;
      end
      // set wins over clear
      if (bus_wr && idx == `SMO_IDX_IRQ_CLR) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[7:0]) | events;
      end else begin
        irq_stat_ff <= irq_stat_ff | events;
      end
      irq <= |(irq_stat_ff & irq_en_ff);
    end
  end
endmodule // smo_top

// ### smo_checker.sv
// port assertions for the sync monitor top
`timescale 1ns/1ns
module smo_checker (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire line_sync_input_a,
  input wire line_sync_input_b,
  input wire frame_sync_input_a,
  input wire frame_sync_input_b,
  input wire green_embedded_sync_input_a,
  input wire green_embedded_sync_input_b,
  input wire green_frame_sync,
  input wire power_down,
  input wire line_sync_repeat,
  input wire frame_sync_repeat,
  input wire pixel_aligned_line_marker,
  input wire active_video_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // bus answer: one access cycle, refusal of unaligned words
  AST_READY_NEXT: assert property (ce && psel && !penable |=> pready)
    else $error("ready missing after setup");
  AST_READY_ONCE: assert property (ce && pready |=> !pready)
    else $error("ready held too long");
  AST_UNALIGNED: assert property (ce && psel && !penable && paddr[1:0] != 2'h0
    |=> pslverr) else $error("unaligned not refused");
  AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // repeats change only with their inputs, never later
  AST_LINE_COPY: assert property ($changed(line_sync_repeat) |-> $changed({
    line_sync_input_a, line_sync_input_b, green_embedded_sync_input_a,
    green_embedded_sync_input_b})) else $error("line repeat not a plain copy");
  AST_FRAME_COPY: assert property (frame_sync_repeat == frame_sync_input_a ||
    frame_sync_repeat == frame_sync_input_b || frame_sync_repeat == green_frame_sync)
    else $error("frame repeat not a copy");
  // pixel logic holds while powered down or not enabled
  AST_PD_HOLD: assert property (power_down |=> $stable(pixel_aligned_line_marker) &&
    $stable(active_video_flag)) else $error("pixel logic moved in power down");
  AST_CE_HOLD: assert property (!ce |=> $stable({prdata, pready, pslverr,
    pixel_aligned_line_marker, active_video_flag})) else $error("state moved without enable");
endmodule // smo_checker

bind smo_top smo_checker u_chk (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .line_sync_input_a(line_sync_input_a),
  .line_sync_input_b(line_sync_input_b), .frame_sync_input_a(frame_sync_input_a),
  .frame_sync_input_b(frame_sync_input_b),
  .green_embedded_sync_input_a(green_embedded_sync_input_a),
  .green_embedded_sync_input_b(green_embedded_sync_input_b),
  .green_frame_sync(green_frame_sync), .power_down(power_down),
  .line_sync_repeat(line_sync_repeat), .frame_sync_repeat(frame_sync_repeat),
  .pixel_aligned_line_marker(pixel_aligned_line_marker),
  .active_video_flag(active_video_flag));

// ### smo_src.sv
// video source model: line pulses, optional glitch, green picture window
`timescale 1ns/1ns
module smo_src #(
  parameter PER = 40
) (
  input wire clk,
  input wire go,
  input wire glitch,
  output reg pulse = 1'b0,
  output reg [7:0] green = 8'h08
);
  integer ph = 0;
  // four clock pulse per line, glitch inside hold-off, bright green 12..29
  always @(posedge clk) begin
    ph <= go ? (ph + 1) % PER : 0;
    pulse <= go && (ph < 4 || (glitch && ph >= 6 && ph < 8));
    green <= (go && ph >= 12 && ph < 30) ? 8'hc8 : 8'h08;
  end
endmodule // smo_src

// ### tb_sync_monitor_and_output.sv
// self-checking bench for the sync monitor block
`timescale 1ns/1ns
module tb_sync_monitor_and_output;
  typedef struct {logic [9:0] a; logic w; logic [31:0] d; logic [31:0] x; logic ex;} smo_row_t;
  reg clk = 1'b0, nrst = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg go = 1'b0, glitch = 1'b0, power_down = 1'b0, e;
  reg [9:0] paddr = 10'h0;
  reg [31:0] pwdata = 32'h0, r, s;
  reg [5:0] msk = 6'h0;
  wire [31:0] prdata;
  wire pready, pslverr, lrep, frep, marker, avf, irq, pulse;
  wire [7:0] green;
  integer err_count = 0, n_tests = 0, k, c, p1;
  // address, write, data, expected read, expected refusal
  smo_row_t rows [10] = '{'{10'h0a8, 1'b0, 32'h0, 32'h20, 1'b0},
    '{10'h0c4, 1'b0, 32'h0, 32'h40, 1'b0}, '{10'h180, 1'b0, 32'h0, 32'h0, 1'b0},
    '{10'h0c4, 1'b1, 32'h7f, 32'h0, 1'b0}, '{10'h0c4, 1'b0, 32'h0, 32'h7f, 1'b0},
    '{10'h008, 1'b1, 32'hff, 32'h0, 1'b0}, '{10'h008, 1'b0, 32'h0, 32'h0, 1'b0},
    '{10'h198, 1'b0, 32'h0, 32'h0, 1'b0}, '{10'h00c, 1'b0, 32'h0, 32'h0, 1'b1},
    '{10'h0a9, 1'b0, 32'h0, 32'h0, 1'b1}};

  always #5 clk = ~clk;

  smo_src u_src (.clk(clk), .go(go), .glitch(glitch), .pulse(pulse), .green(green));
  smo_top #(.ACT_TIMEOUT(200)) u_dut (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_sync_input_a(msk[0] & pulse),
    .frame_sync_input_a(msk[1] & pulse), .green_embedded_sync_input_a(msk[2] & pulse),
    .line_sync_input_b(msk[3] & pulse), .frame_sync_input_b(msk[4] & pulse),
    .green_embedded_sync_input_b(msk[5] & pulse), .green_frame_sync(msk[2] & pulse),
    .green_sample(green), .power_down(power_down), .line_sync_repeat(lrep),
    .frame_sync_repeat(frep), .pixel_aligned_line_marker(marker),
    .active_video_flag(avf), .irq(irq));

  task automatic chk(input string nm, input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one bus transfer, held until ready is sampled high
  task automatic apb(input [9:0] a, input w, input [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr(input [7:0] i, input [31:0] d);
    apb({i, 2'b00}, 1'b1, d);
  endtask

  task automatic rd(input [7:0] i);
    apb({i, 2'b00}, 1'b0, 32'h0);
  endtask

  // high cycles of marker or active flag over one line
  task automatic cnt(input m);
    c = 0;
    repeat (40) begin
      @(posedge clk);
      c += m ? marker : avf;
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard, about three times the expected run
  initial begin
    #600000;
    err_count++;
    end_of_test;
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("reset outputs", {marker, avf, irq, pready}, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("register", r, rows[i].x);
      chk("refusal", e, rows[i].ex);
    end
    // each sync input alone; channel b line sync runs in power down
    for (k = 0; k < 6; k++) begin
      wr(8'h60, (k > 2) | ((k % 3 == 2) ? 2 : 0));
      {msk, go, power_down} <= {6'(1 << k), 1'b1, k == 3};
      repeat (400) @(posedge clk);
      rd(8'h02);
      chk("early activity", r, (k % 3 == 2) ? 0 : 1 << k);
      wait (pulse === 1'b1);
      #1 chk("repeats", {frep, lrep}, (k % 3 == 1) ? 2 : (k == 2) ? 3 : 1);
      repeat (2400) @(posedge clk);
      rd(8'h02);
      chk("activity", r, 1 << k);
      if (k % 3 == 2) chk("green qualified", r[k - 2], 1'b0);
      rd(8'h01);
      chk("selected", {r[6], r[2:0]}, {k > 2, 3'(1 << (k % 3))});
      {go, power_down} <= 2'b00;
      repeat (300) @(posedge clk);
      rd(8'h02);
      chk("idle activity", r, 32'h0);
    end
    // picture window 5..14, then a glitch inside the hold-off
    wr(8'h60, 32'h0);
    wr(8'h61, 32'h5);
    wr(8'h62, 32'hf);
    {msk, go, ce} <= {6'h01, 1'b1, 1'b0};
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    repeat (200) @(posedge clk);
    cnt(1'b0);
    chk("active width", c, 10);
    @(posedge avf);
    #1 p1 = u_src.ph;
    glitch <= 1'b1;
    repeat (200) @(posedge clk);
    @(posedge avf);
    #1 chk("line start", u_src.ph, p1);
    glitch <= 1'b0;
    // marker width and polarity: 8 wide, inverted, off
    for (k = 0; k < 3; k++) begin
      wr(8'h2a, k == 2 ? 0 : 8);
      wr(8'h29, k == 1 ? 8 : 0);
      repeat (100) @(posedge clk);
      cnt(1'b1);
      chk("marker width", c, k == 0 ? 8 : k == 1 ? 32 : 0);
    end
    // marker ends on pixel 0: registered flag rises after pixel 5, seen one edge later
    wr(8'h2a, 32'h8);
    repeat (100) @(posedge clk);
    @(negedge marker);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (avf !== 1'b1 && c < 50);
    chk("marker to flag", c, 7);
    // automatic search, masked then enabled interrupt
    wr(8'h65, 32'h0);
    wr(8'h66, 32'h7);
    wr(8'h50, 32'h4);
    repeat (200) @(posedge clk);
    rd(8'h50);
    chk("auto command", r, 32'h0);
    rd(8'h64);
    chk("auto done masked", {r[1], irq}, 2'b10);
    rd(8'h61);
    s = r;
    rd(8'h62);
    chk("auto window", r - s, 18);
    wr(8'h61, s + 1);
    rd(8'h01);
    chk("three level", r[5], 1'b1);
    wr(8'h65, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq raised", irq, 1'b1);
    wr(8'h66, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    end_of_test;
  end
endmodule // tb_sync_monitor_and_output
